// ---- hw/uml_pkg.sv ----
// Package for the serial port mode/modem control and link/modem status block.
// Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
package uml_pkg;

   // APB byte addresses
   localparam logic [7:0] ADDR_MODEM_MODE_CONTROL   = 8'h04;
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE_REG = 8'h08;
   localparam logic [7:0] ADDR_EXTENDED_CONTROL_ONE = 8'h0c;
   localparam logic [7:0] ADDR_IR_CONTROL_TWO       = 8'h10;
   localparam logic [7:0] ADDR_LINK_STATUS          = 8'h14;
   localparam logic [7:0] ADDR_MODEM_STATUS         = 8'h18;
   localparam logic [7:0] ADDR_AUX_STATUS_CONTROL   = 8'h1c;

   // Reset values and IR-mode modem status constant
   localparam logic [7:0] RST_MODEM_MODE_CONTROL = 8'h00;
   localparam logic [7:0] RST_LINK_STATUS        = 8'h60;
   localparam logic [7:0] MSR_IR_CONSTANT        = 8'h30;

   // Control register field positions
   localparam int MCR_DTR      = 0;
   localparam int MCR_RTS      = 1;
   localparam int MCR_RILP_DMA = 2;
   localparam int MCR_GATE_DFR = 3;
   localparam int MCR_LOOP     = 4;
   localparam int MCR_MODE_LSB = 5;
   localparam int EXC1_EXT     = 0;
   localparam int EXC1_LOOP    = 4;
   localparam int IER_LS       = 2;
   localparam int IER_MS       = 3;
   localparam int IRC2_MSSEL   = 1;

   // Link status field positions
   localparam int LS_RX_DATA_PRESENT  = 0;
   localparam int LS_OVR   = 1;
   localparam int LS_PAR   = 2;
   localparam int LS_FRM   = 3;
   localparam int LS_BRK   = 4;
   localparam int LS_TX_HOLDING_EMPTY = 5;
   localparam int LS_TX_FULLY_IDLE = 6;
   localparam int LS_ERINF = 7;

   // Aux bits cleared by each soft reset
   localparam logic [7:0] AUX_RX_SOFT_MASK = 8'h33;
   localparam logic [7:0] AUX_TX_SOFT_MASK = 8'h44;

   typedef enum logic [2:0] {
      UML_MODE_SERIAL = 3'b000,
      UML_MODE_ASK_IR = 3'b010,
      UML_MODE_SIR    = 3'b011,
      UML_MODE_RC_IR  = 3'b110
   } uml_mode_e;

   typedef enum logic [1:0] {
      UML_RS_IDLE     = 2'b00,
      UML_RS_HUNT     = 2'b01,
      UML_RS_WAIT_ONE = 2'b10
   } uml_resync_e;

endpackage

// ---- hw/uml_ctrl_status.sv ----
// Modem/mode control, link status and modem status registers of a serial port with IR modes.
// Assumes an APB master on clk_sys_i and a receiver/transmitter core on the same clock;
// modem pins are asynchronous and synchronised here.
//
// Functional notes
// - Legacy, no loopback: interrupt output driven only while control bit 3 is one.
// - Loopback bit is one flop shared by control bit 4 and extended bit 4.
// - Extended: interrupt always enabled; loopback only via extended control bit 4.
// - Bits 0/1 drive terminal-ready/request-to-send low; extended loopback fans them out.
// - Extended bit 2 enables DMA; DMA cycles always hit the data holding path.
// - Extended bit 3 enables transmit deferral, effective only with transmit FIFO on.
// - Extended bits 7-5 select serial, amplitude-shift IR, serial IR or remote IR.
// - Mode change flushes FIFOs, clears link status bits 1-4 and aux register; modem deltas only with select bit clear.
// - Link status bits 1-4 sticky until reset, receiver soft reset, mode change or read; reset 60h.
// - Any set link error bit 1-4 raises the link status interrupt when enabled.
// - Bit 0 shows received data waiting in holding register or FIFO.
// - Bit 1 flags overrun; new character dropped; cleared on read.
// - Bit 2 flags parity error as character reaches output; cleared on read.
// - Bit 3 flags zero stop bit as character reaches output; cleared on read.
// - After framing error next zero bit is a start bit, a one bit idles.
// - Bit 4 flags break; after break wait for a one before next start.
// - Bit 5 transmit storage empty, cleared by data write; bit 6 also idle front end.
// - Bit 7 flags errored character in FIFO; zero in legacy non-FIFO; cleared on read.
// - IR mode with select bit set: modem status reads constant 30h.
// - Loopback disconnects modem input pins; status inputs come from control bits.
// - Modem delta bits raise event when enabled; cleared on reset, read, mode change with select bit clear.
// - Deltas on any change of clear-to-send, set-ready, carrier; ring on rising pin.
// - Modem status bits 7-4 show inverted modem input pin levels.
`timescale 1ns/10ps
module uml_ctrl_status (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   // APB slave
   input  wire logic       psel_i,
   input  wire logic       penable_i,
   input  wire logic       pwrite_i,
   input  wire logic [7:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic            pready_o,
   output logic            pslverr_o,
   // Modem pins, active low, asynchronous
   input  wire logic       cts_n_i,
   input  wire logic       dsr_n_i,
   input  wire logic       ri_n_i,
   input  wire logic       dcd_n_i,
   output logic            dtr_n_o,
   output logic            rts_n_o,
   // Receiver core
   input  wire logic       rx_soft_rst_i,
   input  wire logic       rx_fifo_en_i,
   input  wire logic       rx_data_avail_i,
   input  wire logic       rx_store_full_i,
   input  wire logic       rx_char_done_i,
   input  wire logic       rx_char_fe_i,
   input  wire logic       rx_char_brk_i,
   input  wire logic       rx_bit_stb_i,
   input  wire logic       rx_bit_i,
   input  wire logic       rx_head_stb_i,
   input  wire logic       rx_head_pe_i,
   input  wire logic       rx_head_fe_i,
   input  wire logic       rx_head_brk_i,
   input  wire logic       rx_fifo_err_i,
   output logic            rx_char_drop_o,
   output logic            rx_start_o,
   output logic            rx_start_block_o,
   // Transmitter core
   input  wire logic       tx_soft_rst_i,
   input  wire logic       tx_fifo_en_i,
   input  wire logic       tx_data_wr_i,
   input  wire logic       tx_holding_empty_i,
   input  wire logic       tx_front_idle_i,
   output logic            transmit_deferral_on_o,
   // Mode, DMA and interrupt
   input  wire logic       dma_ack_i,
   input  wire logic       irq_src_i,
   output logic [2:0]      operating_mode_sel_o,
   output logic            fifo_flush_o,
   output logic            dma_enable_o,
   output logic            dma_data_path_o,
   output logic            modem_status_event_o,
   output logic            irq_o
);

   logic [3:0] mcr_q;
   logic       loop_q;
   logic [2:0] mode_q;
   logic [7:0] ier_q, exc1_q, irc2_q, aux_q;
   logic [7:0] lsr_q;
   logic       tx_rdy_q;
   logic [3:0] msd_q;
   logic [3:0] sync1_q, sync2_q, prev_q;
   logic [7:0] rd_mux, rd_cap_q;
   logic       rd_hit;
   logic       ext, ir_mode, legacy_nofifo, err_modes, mode_chg, fifo_flush_q;
   logic [2:0] eff_mode, mode_d;
   logic [3:0] lp_act, in_act, delta;
   logic       wr_acc, rd_acc, setup;
   uml_pkg::uml_resync_e rs_q;

   assign setup  = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign rd_acc = psel_i && penable_i && !pwrite_i;
   assign ext    = exc1_q[uml_pkg::EXC1_EXT];
   assign eff_mode = ext ? mode_q : uml_pkg::UML_MODE_SERIAL;
   assign ir_mode  = ext && (mode_q != uml_pkg::UML_MODE_SERIAL);
   assign err_modes = (eff_mode != uml_pkg::UML_MODE_RC_IR);
   assign legacy_nofifo = !ext && !rx_fifo_en_i;

   // Modem pin synchronisers; order {dcd, ri, dsr, cts}
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= {~dcd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
         sync2_q <= sync1_q;
      end
   end

   // Looped inputs, asserted-high, from control bits
   always_comb begin
      if (ext) begin
         lp_act = {mcr_q[uml_pkg::MCR_RTS], mcr_q[uml_pkg::MCR_DTR],
                   mcr_q[uml_pkg::MCR_DTR], mcr_q[uml_pkg::MCR_RTS]};
      end else begin
         lp_act = {mcr_q[uml_pkg::MCR_GATE_DFR], mcr_q[uml_pkg::MCR_RILP_DMA],
                   mcr_q[uml_pkg::MCR_DTR], mcr_q[uml_pkg::MCR_RTS]};
      end
   end
   assign in_act = loop_q ? lp_act : sync2_q;

   // Ring flags on the pin rising, i.e. the asserted level falling
   assign delta = {in_act[3] ^ prev_q[3], prev_q[2] & ~in_act[2],
                   in_act[1] ^ prev_q[1], in_act[0] ^ prev_q[0]};

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prev_q <= 4'h0;
      end else begin
         prev_q <= in_act;
      end
   end

   // Control registers
   always_comb begin
      mode_d = mode_q;
      if (wr_acc && paddr_i == uml_pkg::ADDR_MODEM_MODE_CONTROL && ext) begin
         mode_d = pwdata_i[uml_pkg::MCR_MODE_LSB +: 3];
      end
   end
   assign mode_chg = (mode_d != mode_q);

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mcr_q  <= uml_pkg::RST_MODEM_MODE_CONTROL[3:0];
         loop_q <= 1'b0;
         mode_q <= uml_pkg::RST_MODEM_MODE_CONTROL[7:5];
         ier_q  <= 8'h00;
         exc1_q <= 8'h00;
         irc2_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         if (wr_acc) begin
            case (paddr_i)
               uml_pkg::ADDR_MODEM_MODE_CONTROL: begin
                  mcr_q <= pwdata_i[3:0];
                  if (!ext) begin
                     loop_q <= pwdata_i[uml_pkg::MCR_LOOP];
                  end
               end
               uml_pkg::ADDR_EXTENDED_CONTROL_ONE: begin
                  exc1_q <= pwdata_i[7:0];
                  loop_q <= pwdata_i[uml_pkg::EXC1_LOOP];
               end
               uml_pkg::ADDR_INTERRUPT_ENABLE_REG: ier_q  <= pwdata_i[7:0];
               uml_pkg::ADDR_IR_CONTROL_TWO:       irc2_q <= pwdata_i[7:0];
               default: ;
            endcase
         end
      end
   end

   // Aux register: only its write and clearing behaviour live here
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aux_q <= 8'h00;
      end else if (mode_chg) begin
         aux_q <= 8'h00;
      end else begin
         if (wr_acc && paddr_i == uml_pkg::ADDR_AUX_STATUS_CONTROL) begin
            aux_q <= pwdata_i[7:0];
         end else begin
            aux_q <= aux_q & ~({8{rx_soft_rst_i}} & uml_pkg::AUX_RX_SOFT_MASK)
                           & ~({8{tx_soft_rst_i}} & uml_pkg::AUX_TX_SOFT_MASK);
         end
      end
   end

   // Link status; new events win over a same-cycle clear
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lsr_q <= uml_pkg::RST_LINK_STATUS;
      end else begin
         logic [7:0] clr, set;
         clr = 8'h00;
         set = 8'h00;
         // Only bits the read actually returned are cleared, so nothing is lost
         if (rd_acc && paddr_i == uml_pkg::ADDR_LINK_STATUS) begin
            clr = rd_cap_q & 8'h9e;
         end
         if (rx_soft_rst_i || mode_chg) begin
            clr = clr | 8'h1e;
         end
         set[uml_pkg::LS_OVR] = rx_char_done_i && rx_store_full_i;
         if (rx_head_stb_i && err_modes) begin
            set[uml_pkg::LS_PAR] = rx_head_pe_i;
            set[uml_pkg::LS_FRM] = rx_head_fe_i;
            set[uml_pkg::LS_BRK] = rx_head_brk_i;
         end
         set[uml_pkg::LS_ERINF] = rx_fifo_err_i && !legacy_nofifo && err_modes;
         lsr_q[4:1] <= (lsr_q[4:1] & ~clr[4:1]) | set[4:1];
         lsr_q[uml_pkg::LS_ERINF] <= legacy_nofifo ? 1'b0 :
            ((lsr_q[uml_pkg::LS_ERINF] & ~clr[uml_pkg::LS_ERINF]) | set[uml_pkg::LS_ERINF]);
         lsr_q[uml_pkg::LS_RX_DATA_PRESENT]  <= rx_data_avail_i;
         lsr_q[uml_pkg::LS_TX_FULLY_IDLE] <= tx_rdy_q && tx_front_idle_i;
         lsr_q[uml_pkg::LS_TX_HOLDING_EMPTY] <= tx_rdy_q;
      end
   end

   // Transmit ready drops on a data write and returns when storage drains
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_rdy_q <= 1'b1;
      end else if (tx_data_wr_i) begin
         tx_rdy_q <= 1'b0;
      end else if (tx_holding_empty_i) begin
         tx_rdy_q <= 1'b1;
      end
   end

   // Modem status deltas
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         msd_q <= 4'h0;
      end else begin
         logic [3:0] clr;
         clr = 4'h0;
         if (rd_acc && paddr_i == uml_pkg::ADDR_MODEM_STATUS) begin
            clr = rd_cap_q[3:0];
         end
         if (mode_chg && !irc2_q[uml_pkg::IRC2_MSSEL]) begin
            clr = 4'hf;
         end
         msd_q <= (msd_q & ~clr) | delta;
      end
   end

   // Resynchronisation after framing error or break
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rs_q <= uml_pkg::UML_RS_IDLE;
      end else if (rx_soft_rst_i) begin
         rs_q <= uml_pkg::UML_RS_IDLE;
      end else if (rx_char_done_i && rx_char_brk_i) begin
         rs_q <= uml_pkg::UML_RS_WAIT_ONE;
      end else if (rx_char_done_i && rx_char_fe_i) begin
         rs_q <= uml_pkg::UML_RS_HUNT;
      end else if (rx_bit_stb_i) begin
         case (rs_q)
            uml_pkg::UML_RS_HUNT:     rs_q <= uml_pkg::UML_RS_IDLE;
            uml_pkg::UML_RS_WAIT_ONE: begin
               if (rx_bit_i) begin
                  rs_q <= uml_pkg::UML_RS_IDLE;
               end
            end
            default:                  rs_q <= uml_pkg::UML_RS_IDLE;
         endcase
      end
   end
   assign rx_start_o = (rs_q == uml_pkg::UML_RS_HUNT) && rx_bit_stb_i && !rx_bit_i;
   assign rx_start_block_o = (rs_q == uml_pkg::UML_RS_WAIT_ONE);
   assign rx_char_drop_o = rx_char_done_i && rx_store_full_i;

   // Read mux
   always_comb begin
      rd_mux = 8'h00;
      rd_hit = 1'b1;
      case (paddr_i)
         uml_pkg::ADDR_MODEM_MODE_CONTROL:
            rd_mux = ext ? {mode_q, 1'b0, mcr_q} : {3'b000, loop_q, mcr_q};
         uml_pkg::ADDR_INTERRUPT_ENABLE_REG: rd_mux = ier_q;
         uml_pkg::ADDR_EXTENDED_CONTROL_ONE:
            rd_mux = {exc1_q[7:5], loop_q, exc1_q[3:0]};
         uml_pkg::ADDR_IR_CONTROL_TWO:       rd_mux = irc2_q;
         uml_pkg::ADDR_LINK_STATUS:          rd_mux = lsr_q;
         uml_pkg::ADDR_MODEM_STATUS:
            rd_mux = (ir_mode && irc2_q[uml_pkg::IRC2_MSSEL]) ?
                     uml_pkg::MSR_IR_CONSTANT : {in_act, msd_q};
         uml_pkg::ADDR_AUX_STATUS_CONTROL:   rd_mux = aux_q;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read data captured in the setup cycle and held through the access
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_cap_q <= 8'h00;
      end else if (setup && !pwrite_i) begin
         rd_cap_q <= rd_mux;
      end
   end
   assign prdata_o  = {24'h000000, rd_cap_q};
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !rd_hit;

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fifo_flush_q <= 1'b0;
      end else begin
         fifo_flush_q <= mode_chg;
      end
   end

   // Outputs
   assign fifo_flush_o = fifo_flush_q;
   assign dtr_n_o = ~mcr_q[uml_pkg::MCR_DTR];
   assign rts_n_o = ~mcr_q[uml_pkg::MCR_RTS];
   assign operating_mode_sel_o = eff_mode;
   assign dma_enable_o = ext && mcr_q[uml_pkg::MCR_RILP_DMA];
   // Software is expected to mask tx/rx interrupts itself while DMA runs
   assign dma_data_path_o = dma_enable_o && dma_ack_i;
   assign transmit_deferral_on_o = ext && mcr_q[uml_pkg::MCR_GATE_DFR] && tx_fifo_en_i;
   assign modem_status_event_o = (msd_q != 4'h0) && ier_q[uml_pkg::IER_MS];

   logic irq_req, irq_gate;
   assign irq_req = irq_src_i || modem_status_event_o ||
                    ((lsr_q[4:1] != 4'h0) && ier_q[uml_pkg::IER_LS]);
   assign irq_gate = ext || loop_q || mcr_q[uml_pkg::MCR_GATE_DFR];
   assign irq_o = irq_req && irq_gate;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   // Gate off means no request may leave, whatever the sources say
   AST_LEGACY_GATE: assert property (!ext && !loop_q && !mcr_q[uml_pkg::MCR_GATE_DFR]
         |-> !irq_o)
      else $error("interrupt driven while gated off");
   AST_LOOP_WRITE: assert property (wr_acc && !ext && paddr_i == uml_pkg::ADDR_MODEM_MODE_CONTROL
         |=> loop_q == $past(pwdata_i[uml_pkg::MCR_LOOP]))
      else $error("loopback bit not stored");
   AST_EXT_GATE: assert property (ext && irq_src_i |-> irq_o)
      else $error("extended interrupt blocked");
   AST_EXT_LOOP_FAN: assert property (ext && loop_q |-> in_act[1] == in_act[2])
      else $error("loopback set-ready and ring differ");
   AST_DEFER_FIFO: assert property (!tx_fifo_en_i |-> !transmit_deferral_on_o)
      else $error("deferral without transmit FIFO");
   AST_MODE_FLUSH: assert property (mode_chg |=> fifo_flush_o && aux_q == 8'h00 ##1 !fifo_flush_o)
      else $error("mode change did not flush");
   AST_OVERRUN: assert property (rx_char_done_i && rx_store_full_i |=> lsr_q[1] ##1 lsr_q[1] || $past(rd_acc) || $past(rx_soft_rst_i) || $past(mode_chg))
      else $error("overrun not flagged");
   AST_IR_CONST: assert property (setup && !pwrite_i && paddr_i == uml_pkg::ADDR_MODEM_STATUS
         && ir_mode && irc2_q[uml_pkg::IRC2_MSSEL]
         |=> prdata_o[7:0] == uml_pkg::MSR_IR_CONSTANT)
      else $error("modem status not constant in IR mode");
   AST_TX_IDLE: assert property (lsr_q[6] |-> lsr_q[5])
      else $error("transmitter empty without ready");

endmodule

// ---- bench/uml_modem_model.sv ----
// Behavioural modem standing on the far side of the four modem status pins.
// Assumes the bench asks for asserted line levels; pins move just after a rising edge.
`timescale 1ns/10ps
module uml_modem_model (
   // Clock
   input  wire logic       clk_sys_i,
   // Requested asserted levels {carrier, ring, set_ready, clear_to_send}
   input  wire logic [3:0] line_on_i,
   // Modem pins, active low
   output logic            cts_n_o,
   output logic            dsr_n_o,
   output logic            ri_n_o,
   output logic            dcd_n_o
);
   // Pins are active low, so an asserted line is driven to 0
   always_ff @(posedge clk_sys_i) begin
      {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= ~line_on_i;
   end
endmodule

// ---- bench/uml_ctrl_status_bench.sv ----
// Self-checking bench for the control and status register block.
// Assumes zero-wait APB answers and a behavioural modem on the status pins.
`timescale 1ns/10ps
module uml_ctrl_status_bench;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} uml_row_s;
   logic clk_sys_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, dtr_n_o, rts_n_o;
   logic rx_soft_rst_i, rx_fifo_en_i, rx_data_avail_i, rx_store_full_i, rx_char_done_i;
   logic rx_char_fe_i, rx_char_brk_i, rx_bit_stb_i, rx_bit_i, rx_head_stb_i, rx_head_pe_i;
   logic rx_head_fe_i, rx_head_brk_i, rx_fifo_err_i, rx_char_drop_o, rx_start_o;
   logic rx_start_block_o, tx_soft_rst_i, tx_fifo_en_i, tx_data_wr_i, tx_holding_empty_i;
   logic tx_front_idle_i, transmit_deferral_on_o, dma_ack_i, irq_src_i, fifo_flush_o;
   logic dma_enable_o, dma_data_path_o, modem_status_event_o, irq_o, seen;
   logic [2:0]  operating_mode_sel_o;
   logic [3:0]  line_on;
   int          err_total, checks, n;
   uml_row_s    rows [4];
   logic [2:0]  modes [4];

   uml_ctrl_status DUT (
      .clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .cts_n_i, .dsr_n_i, .ri_n_i, .dcd_n_i, .dtr_n_o,
      .rts_n_o, .rx_soft_rst_i, .rx_fifo_en_i, .rx_data_avail_i, .rx_store_full_i,
      .rx_char_done_i, .rx_char_fe_i, .rx_char_brk_i, .rx_bit_stb_i, .rx_bit_i,
      .rx_head_stb_i, .rx_head_pe_i, .rx_head_fe_i, .rx_head_brk_i, .rx_fifo_err_i,
      .rx_char_drop_o, .rx_start_o, .rx_start_block_o, .tx_soft_rst_i, .tx_fifo_en_i,
      .tx_data_wr_i, .tx_holding_empty_i, .tx_front_idle_i, .transmit_deferral_on_o,
      .dma_ack_i, .irq_src_i, .operating_mode_sel_o, .fifo_flush_o, .dma_enable_o,
      .dma_data_path_o, .modem_status_event_o, .irq_o);

   uml_modem_model modem (.clk_sys_i(clk_sys_i), .line_on_i(line_on), .cts_n_o(cts_n_i),
      .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i), .dcd_n_o(dcd_n_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic print_verdict();
      if (err_total == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Request held unchanged until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys_i);
      psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk_sys_i);
         if (pready_o === 1'b1) break;
      end
      q = prdata_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      if (n == 16) begin
         err_total++;
         print_verdict();
      end
   endtask

   task automatic wait_edges(input int k);
      repeat (k) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask

   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {rx_soft_rst_i, rx_fifo_en_i, rx_data_avail_i, rx_store_full_i, rx_char_done_i} = '0;
      {rx_char_fe_i, rx_char_brk_i, rx_bit_stb_i, rx_bit_i, rx_head_stb_i} = '0;
      {rx_head_pe_i, rx_head_fe_i, rx_head_brk_i, rx_fifo_err_i, tx_soft_rst_i} = '0;
      {tx_fifo_en_i, tx_data_wr_i, dma_ack_i, irq_src_i, line_on} = '0;
      {tx_holding_empty_i, tx_front_idle_i, sys_rst_i} = 3'b111;
      err_total = 0; checks = 0;
      rows = '{'{uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'he3, 32'h03},
               '{uml_pkg::ADDR_LINK_STATUS, 32'hff, 32'h60},
               '{8'h20, 32'h5a, 32'h00},
               '{uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h00, 32'h00}};
      modes = '{3'b010, 3'b011, 3'b110, 3'b000};
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      apb(0, uml_pkg::ADDR_MODEM_MODE_CONTROL, 0, rd); chk(rd, 32'h00);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd, 32'h60);
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].d, rd);
         apb(0, rows[i].a, 0, rd); chk(rd, rows[i].e);
      end
      irq_src_i <= 1'b1;
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h00, rd); wait_edges(0); chk(irq_o, 0);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h08, rd); wait_edges(0); chk(irq_o, 1);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h10, rd); wait_edges(0); chk(irq_o, 1);
      // Legacy loopback: every status input follows a control bit
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h1f, rd); wait_edges(4);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd & 32'hf0, 32'hf0);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h00, rd);
      apb(1, uml_pkg::ADDR_EXTENDED_CONTROL_ONE, 32'h11, rd);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h11, rd); wait_edges(4);
      chk({dtr_n_o, rts_n_o, irq_o}, 3'b011);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd & 32'hf0, 32'h60);
      apb(0, uml_pkg::ADDR_MODEM_MODE_CONTROL, 0, rd); chk(rd, 32'h01);
      apb(1, uml_pkg::ADDR_EXTENDED_CONTROL_ONE, 32'h10, rd);
      apb(0, uml_pkg::ADDR_MODEM_MODE_CONTROL, 0, rd); chk(rd, 32'h11);
      apb(1, uml_pkg::ADDR_EXTENDED_CONTROL_ONE, 32'h01, rd);
      apb(1, uml_pkg::ADDR_MODEM_STATUS, 0, rd);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h0c, rd);
      tx_fifo_en_i <= 1'b1; dma_ack_i <= 1'b1; wait_edges(1);
      chk({transmit_deferral_on_o, dma_enable_o, dma_data_path_o}, 3'b111);
      tx_fifo_en_i <= 1'b0; wait_edges(1); chk(transmit_deferral_on_o, 0);
      line_on <= 4'b0001; wait_edges(4);
      foreach (modes[i]) begin
         apb(1, uml_pkg::ADDR_AUX_STATUS_CONTROL, 32'hff, rd);
         apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, {24'h0, modes[i], 5'h00}, rd);
         seen = 1'b0;
         for (int k = 0; k < 3; k++) begin
            @(negedge clk_sys_i);
            if (fifo_flush_o === 1'b1) seen = 1'b1;
         end
         chk({seen, operating_mode_sel_o}, {1'b1, modes[i]});
         apb(0, uml_pkg::ADDR_AUX_STATUS_CONTROL, 0, rd); chk(rd, 32'h00);
         apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd, 32'h10);
      end
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h60, rd);
      apb(1, uml_pkg::ADDR_IR_CONTROL_TWO, 32'h02, rd);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd, 32'h30);
      apb(1, uml_pkg::ADDR_IR_CONTROL_TWO, 32'h00, rd);
      apb(1, uml_pkg::ADDR_MODEM_MODE_CONTROL, 32'h00, rd);
      line_on <= 4'b0000; irq_src_i <= 1'b0;
      apb(1, uml_pkg::ADDR_INTERRUPT_ENABLE_REG, 32'h0c, rd);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd);
      // Overrun: character dropped, sticky flag, interrupt, cleared by read
      rx_store_full_i <= 1'b1; rx_char_done_i <= 1'b1; wait_edges(1);
      chk(rx_char_drop_o, 1);
      rx_char_done_i <= 1'b0; wait_edges(2); chk(irq_o, 1);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd, 32'h62);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd, 32'h60);
      wait_edges(0); chk(irq_o, 0);
      rx_char_done_i <= 1'b1; wait_edges(0);
      rx_char_done_i <= 1'b0; rx_soft_rst_i <= 1'b1; wait_edges(0);
      rx_soft_rst_i <= 1'b0; rx_store_full_i <= 1'b0; wait_edges(2);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd, 32'h60);
      rx_fifo_en_i <= 1'b1; rx_head_stb_i <= 1'b1; rx_fifo_err_i <= 1'b1;
      {rx_head_pe_i, rx_head_fe_i, rx_head_brk_i} <= 3'b111; wait_edges(1);
      rx_head_stb_i <= 1'b0; {rx_head_pe_i, rx_head_fe_i, rx_head_brk_i} <= 3'b000;
      wait_edges(2);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd, 32'hfc);
      rx_fifo_err_i <= 1'b0; wait_edges(2);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd & 32'h7f, 32'h60);
      rx_data_avail_i <= 1'b1; {tx_holding_empty_i, tx_front_idle_i} <= 2'b10; wait_edges(2);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd & 32'h7f, 32'h21);
      rx_data_avail_i <= 1'b0; tx_holding_empty_i <= 1'b0; tx_data_wr_i <= 1'b1; wait_edges(1);
      tx_data_wr_i <= 1'b0; wait_edges(2);
      apb(0, uml_pkg::ADDR_LINK_STATUS, 0, rd); chk(rd & 32'h7f, 32'h00);
      // Ring asserted then released: only the release sets the ring delta
      line_on <= 4'b0100; wait_edges(4);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd, 32'h40);
      line_on <= 4'b0000; wait_edges(4); chk(modem_status_event_o, 1);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd, 32'h04);
      line_on <= 4'b1000; wait_edges(4);
      apb(0, uml_pkg::ADDR_MODEM_STATUS, 0, rd); chk(rd, 32'h88);
      print_verdict();
   end
endmodule
